//--- rtl/apbss_regs.svh
`ifndef APBSS_REGS_SVH
`define APBSS_REGS_SVH

// ==========================================================
// Slot map: address bits 15:12 pick one 4 KB slot
// ==========================================================
`define APBSS_SLOT_MSB 15
`define APBSS_SLOT_LSB 12
`define APBSS_SLOT_COUNT 16
`define APBSS_OFFS_MSB 11

`define APBSS_BASE_TIMER_A 16'h0000
`define APBSS_BASE_TIMER_B 16'h1000
`define APBSS_BASE_TWIN_TIMER 16'h2000
`define APBSS_BASE_UNUSED_A 16'h3000
`define APBSS_BASE_SERIAL_A 16'h4000
`define APBSS_BASE_SERIAL_B 16'h5000
`define APBSS_BASE_SERIAL_C 16'h6000
`define APBSS_BASE_UNUSED_B 16'h7000
`define APBSS_BASE_WATCHDOG 16'h8000
`define APBSS_BASE_UNUSED_C 16'h9000
`define APBSS_BASE_UNUSED_D 16'hA000
`define APBSS_BASE_TEST_SLAVE 16'hB000
`define APBSS_BASE_EXT_FIRST 16'hC000
`define APBSS_BASE_EXT_LAST 16'hF000

`define APBSS_SLOT_TIMER_A 4'h0
`define APBSS_SLOT_TIMER_B 4'h1
`define APBSS_SLOT_TWIN_TIMER 4'h2
`define APBSS_SLOT_SERIAL_A 4'h4
`define APBSS_SLOT_WATCHDOG 4'h8
`define APBSS_SLOT_TEST_SLAVE 4'hB
`define APBSS_SLOT_EXT_FIRST 4'hC

// ==========================================================
// Interrupt vector bit positions
// ==========================================================
`define APBSS_IRQ_WIDTH 32
`define APBSS_IRQ_SERIAL_BASE 0
`define APBSS_IRQ_TIMER_A 8
`define APBSS_IRQ_TIMER_B 9
`define APBSS_IRQ_TWIN_TIMER 10
`define APBSS_IRQ_OVF_BASE 12
`define APBSS_IRQ_USED_MASK 32'h0000_773F

// ==========================================================
// Reset values and default answers
// ==========================================================
`define APBSS_DATA_RESET 32'h0000_0000
`define APBSS_IRQ_RESET 32'h0000_0000
`define APBSS_SYNC_STAGES 3

`endif

//--- rtl/apbss_pkg.sv
package apbss_pkg;

	// ==========================================================
	// Carriers
	// ==========================================================
	typedef struct packed {
		logic [11:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} apbss_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apbss_rsp_t;

	// ==========================================================
	// Transfer sequencer states
	// ==========================================================
	typedef enum logic [1:0] {
		APBSS_IDLE,
		APBSS_SETUP,
		APBSS_ACCESS,
		APBSS_DONE
	} apbss_state_t;

endpackage

//--- rtl/apbss_irq_sync.sv
`include "apbss_regs.svh"

module apbss_irq_sync #(
	parameter int WIDTH = 32,
	parameter bit ENABLE = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Interrupt lines
	input wire logic [WIDTH-1:0] irq_in,
	output logic [WIDTH-1:0] irq_out
);
	import apbss_pkg::*;

	// ==========================================================
	// Per-line synchroniser, or straight wire when left out
	// ==========================================================
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_line
			if (ENABLE) begin : g_sync
				logic ff1_r, ff2_r, ff3_r, out_r, out_nxt;
				always_comb begin
					out_nxt = out_r;
					// Change counts only once stages two and three agree
					if (ff2_r == ff3_r) begin
						out_nxt = ff3_r;
					end
				end
				always_ff @(posedge clk or negedge rst_b) begin
					if (!rst_b) begin
						ff1_r <= 1'b0;
						ff2_r <= 1'b0;
						ff3_r <= 1'b0;
						out_r <= 1'b0;
					end else begin
						ff1_r <= irq_in[i];
						ff2_r <= ff1_r;
						ff3_r <= ff2_r;
						out_r <= out_nxt;
					end
				end
				assign irq_out[i] = out_r;
			end else begin : g_direct
				assign irq_out[i] = irq_in[i];
			end
		end
	endgenerate

endmodule

//--- rtl/apbss_top.sv
// Functional notes
// RULE1: include_test_slave build flag adds or removes test slave, default on.
// RULE2: Timer A, timer B and twin timer each have an include flag, default on.
// RULE3: Serial A, B and C each have an include flag, default on.
// RULE4: include_watchdog build flag adds or removes the watchdog slot.
// RULE5: big_endian_sel 0 little-endian default; 1 byte-swaps data, costs hardware.
// RULE6: Expansion ports stay disabled unless enabled by build flag.
// RULE7: Bus-side logic runs on gated peripheral clock derived from free clock.
// RULE8: Outside logic may stop the gated clock while no transfer is active.
// RULE9: Timer A at 0x0000, timer B at 0x1000, twin timer at 0x2000.
// RULE10: Serial A 0x4000, B 0x5000, C 0x6000; watchdog at 0x8000.
// RULE11: Test slave slot sits at 0xB000.
// RULE12: Expansion ports 12 to 15 occupy slots 0xC000 to 0xF000.
// RULE13: Slots 0x3000, 0x7000, 0x9000, 0xA000 are never selected.
// RULE14: Serial n receive irq on bit 2n, transmit irq on bit 2n+1.
// RULE15: Timer A irq bit 8, timer B bit 9, twin timer bit 10.
// RULE16: Serial A, B, C overflow irqs on bits 12, 13, 14.
// RULE17: Bits 6, 7, 11, 15 and 16 to 31 stay low.
// RULE18: include_irq_sync adds interrupt synchronisers; default off passes lines straight.
// RULE19: Each slot gives select; takes ready, 32-bit read data, slave error.
// RULE20: Slot chosen by address bits 15:12; disabled slot completes quietly.
//
// Local design decisions: the APB slave port and the placing of the registers.
`include "apbss_regs.svh"

module apbss_top #(
	parameter bit include_test_slave = 1'b1,
	parameter bit include_timer_a = 1'b1,
	parameter bit include_timer_b = 1'b1,
	parameter bit include_twin_timer = 1'b1,
	parameter bit include_serial_a = 1'b1,
	parameter bit include_serial_b = 1'b1,
	parameter bit include_serial_c = 1'b1,
	parameter bit include_watchdog = 1'b1,
	parameter bit big_endian_sel = 1'b0,
	parameter bit include_irq_sync = 1'b0,
	parameter logic [3:0] ext_port_en = 4'h0
) (
	// Gated peripheral clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave port from the bridge
	input wire logic psel,
	input wire logic penable,
	input wire logic [15:0] paddr,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Clock gating
	input wire logic bus_activity_flag,
	output logic gated_periph_clk_en,
	// Slot ports: shared request and enable, one select and answer per 4 KB slot
	output apbss_pkg::apbss_req_t slot_req,
	output logic slot_penable,
	output logic [15:0] slot_psel,
	input wire apbss_pkg::apbss_rsp_t [15:0] slot_rsp,
	// Peripheral interrupt lines
	input wire logic [2:0] serial_rx_irq,
	input wire logic [2:0] serial_tx_irq,
	input wire logic [2:0] serial_ovf_irq,
	input wire logic timer_a_irq,
	input wire logic timer_b_irq,
	input wire logic twin_timer_irq,
	// Interrupt vector
	output logic [31:0] irq_vec
);
	import apbss_pkg::*;

	// ==========================================================
	// Build-time slot enables
	// ==========================================================
	localparam logic [2:0] serial_en = {include_serial_c, include_serial_b, include_serial_a};
	localparam logic [15:0] slot_en = {
		ext_port_en,           // [RULE6] [RULE12]
		include_test_slave,    // [RULE1] [RULE11]
		2'b00,                 // [RULE13]
		include_watchdog,      // [RULE4] [RULE10]
		1'b0,                  // [RULE13]
		serial_en,             // [RULE3] [RULE10]
		1'b0,                  // [RULE13]
		include_twin_timer,    // [RULE2] [RULE9]
		include_timer_b,
		include_timer_a
	};

	function automatic logic [31:0] byte_swap(input logic [31:0] d);
		byte_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	// ==========================================================
	// Transfer sequencer state
	// ==========================================================
	apbss_state_t state_r, state_nxt;
	logic [15:0] sel_r, sel_nxt;
	apbss_req_t req_r, req_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	apbss_rsp_t rsp_mux;
	logic [3:0] slot_idx;
	logic setup_seen;

	assign slot_idx = paddr[`APBSS_SLOT_MSB:`APBSS_SLOT_LSB];    // [RULE20]
	assign setup_seen = psel && !penable;

	// Answer of the slot currently selected
	always_comb begin
		rsp_mux = '0;
		for (int s = 0; s < `APBSS_SLOT_COUNT; s++) begin
			if (sel_r[s]) begin
				rsp_mux = rsp_mux | slot_rsp[s];    // [RULE19]
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		req_nxt = req_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		case (state_r)
			APBSS_IDLE: begin
				if (setup_seen) begin
					req_nxt.paddr = paddr[`APBSS_OFFS_MSB:0];
					req_nxt.pwrite = pwrite;
					// [RULE5]
					req_nxt.pwdata = big_endian_sel ? byte_swap(pwdata) : pwdata;
					prdata_nxt = `APBSS_DATA_RESET;
					pslverr_nxt = 1'b0;
					if (slot_en[slot_idx]) begin
						sel_nxt = 16'h0001 << slot_idx;    // [RULE20]
						state_nxt = APBSS_SETUP;
					end else begin
						// Removed or unused slot: finish here, reach nobody
						sel_nxt = 16'h0000;    // [RULE13] [RULE20]
						state_nxt = APBSS_DONE;
					end
				end
			end
			APBSS_SETUP: begin
				state_nxt = APBSS_ACCESS;
			end
			APBSS_ACCESS: begin
				if (rsp_mux.pready) begin    // [RULE19]
					if (!req_r.pwrite) begin
						prdata_nxt = big_endian_sel ? byte_swap(rsp_mux.prdata) :
							rsp_mux.prdata;    // [RULE5]
					end
					pslverr_nxt = rsp_mux.pslverr;
					sel_nxt = 16'h0000;
					state_nxt = APBSS_DONE;
				end
			end
			APBSS_DONE: begin
				state_nxt = APBSS_IDLE;
			end
			default: begin
				state_nxt = APBSS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= APBSS_IDLE;
			sel_r <= 16'h0000;
			req_r <= '0;
			prdata_r <= `APBSS_DATA_RESET;
			pslverr_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			req_r <= req_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ==========================================================
	// Bus outputs
	// ==========================================================
	assign pready = (state_r == APBSS_DONE);
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign slot_req = req_r;
	assign slot_penable = (state_r == APBSS_ACCESS);
	// Only enabled slots can ever be selected
	assign slot_psel = ((state_r == APBSS_SETUP) || (state_r == APBSS_ACCESS)) ?
		(sel_r & slot_en) : 16'h0000;    // [RULE19] [RULE13]

	// Gate request for the gated clock: stay running while anything is in flight
	assign gated_periph_clk_en = bus_activity_flag || psel ||
		(state_r != APBSS_IDLE);    // [RULE7] [RULE8]

	// ==========================================================
	// Interrupt vector
	// ==========================================================
	logic [31:0] irq_raw;

	always_comb begin
		irq_raw = `APBSS_IRQ_RESET;    // [RULE17]
		for (int u = 0; u < 3; u++) begin
			irq_raw[`APBSS_IRQ_SERIAL_BASE + 2 * u] = serial_rx_irq[u] & serial_en[u];
			irq_raw[`APBSS_IRQ_SERIAL_BASE + 2 * u + 1] = serial_tx_irq[u] & serial_en[u];
			irq_raw[`APBSS_IRQ_OVF_BASE + u] = serial_ovf_irq[u] & serial_en[u];    // [RULE16]
		end
		irq_raw[`APBSS_IRQ_TIMER_A] = timer_a_irq & include_timer_a;    // [RULE15]
		irq_raw[`APBSS_IRQ_TIMER_B] = timer_b_irq & include_timer_b;
		irq_raw[`APBSS_IRQ_TWIN_TIMER] = twin_timer_irq & include_twin_timer;
	end    // [RULE14]

	apbss_irq_sync #(
		.WIDTH(`APBSS_IRQ_WIDTH),
		.ENABLE(include_irq_sync)    // [RULE18]
	) u_irq_sync (
		.clk(clk),
		.rst_b(rst_b),
		.irq_in(irq_raw),
		.irq_out(irq_vec)
	);

	// ==========================================================
	// Checks
	// ==========================================================
	property p_unused_slots_quiet;
		@(posedge clk) disable iff (!rst_b)
		(slot_psel[3] | slot_psel[7] | slot_psel[9] | slot_psel[10]) == 1'b0;
	endproperty
	a_unused_slots_quiet: assert property (p_unused_slots_quiet)    // [RULE13]
		else $error("unused slot selected");

	property p_decode_target;
		@(posedge clk) disable iff (!rst_b)
		(state_r == APBSS_IDLE && setup_seen && slot_en[slot_idx]) |=>
			(slot_psel == (16'h0001 << $past(slot_idx)));
	endproperty
	a_decode_target: assert property (p_decode_target)    // [RULE20]
		else $error("wrong slot selected for address");

	property p_disabled_completes;
		@(posedge clk) disable iff (!rst_b)
		(state_r == APBSS_IDLE && setup_seen && !slot_en[slot_idx]) |=>
			(pready && !pslverr && prdata == 32'h0000_0000 && slot_psel == 16'h0000);
	endproperty
	a_disabled_completes: assert property (p_disabled_completes)    // [RULE20]
		else $error("disabled slot did not complete quietly");

	property p_slot_setup_then_access;
		@(posedge clk) disable iff (!rst_b)
		$rose(slot_penable) |-> ($past(slot_psel) != 16'h0000) && $stable(slot_psel);
	endproperty
	a_slot_setup_then_access: assert property (p_slot_setup_then_access)    // [RULE19]
		else $error("slot access phase without setup");

	property p_answer_follows_ready;
		@(posedge clk) disable iff (!rst_b)
		(slot_penable && (|(slot_psel & slot_en)) && rsp_mux.pready) |=>
			pready ##1 !pready;
	endproperty
	a_answer_follows_ready: assert property (p_answer_follows_ready)    // [RULE19]
		else $error("answer not one cycle after slot ready");

	property p_read_data_order;
		@(posedge clk) disable iff (!rst_b)
		(slot_penable && rsp_mux.pready && !req_r.pwrite) |=>
			(prdata == (big_endian_sel ? byte_swap($past(rsp_mux.prdata)) :
				$past(rsp_mux.prdata)));
	endproperty
	a_read_data_order: assert property (p_read_data_order)    // [RULE5]
		else $error("read data byte order wrong");

	property p_reserved_irq_low;
		@(posedge clk) disable iff (!rst_b)
		(irq_vec & ~`APBSS_IRQ_USED_MASK) == 32'h0000_0000;
	endproperty
	a_reserved_irq_low: assert property (p_reserved_irq_low)    // [RULE17]
		else $error("reserved interrupt bit driven");

	property p_timer_irq_map;
		@(posedge clk) disable iff (!rst_b)
		!include_irq_sync |-> (irq_vec[10:8] ==
			{twin_timer_irq & include_twin_timer, timer_b_irq & include_timer_b,
			timer_a_irq & include_timer_a});
	endproperty
	a_timer_irq_map: assert property (p_timer_irq_map)    // [RULE15]
		else $error("timer interrupt on wrong bit");

	property p_serial_irq_map;
		@(posedge clk) disable iff (!rst_b)
		!include_irq_sync |-> (irq_vec[5:0] == ({serial_tx_irq[2], serial_rx_irq[2],
			serial_tx_irq[1], serial_rx_irq[1], serial_tx_irq[0], serial_rx_irq[0]} &
			{{2{serial_en[2]}}, {2{serial_en[1]}}, {2{serial_en[0]}}}));
	endproperty
	a_serial_irq_map: assert property (p_serial_irq_map)    // [RULE14]
		else $error("serial interrupt on wrong bit");

	property p_overflow_irq_map;
		@(posedge clk) disable iff (!rst_b)
		!include_irq_sync |-> (irq_vec[14:12] == (serial_ovf_irq & serial_en));
	endproperty
	a_overflow_irq_map: assert property (p_overflow_irq_map)    // [RULE16]
		else $error("overflow interrupt on wrong bit");

	property p_sync_latency;
		@(posedge clk) disable iff (!rst_b)
		(include_irq_sync && include_timer_a && $rose(timer_a_irq)) ##1
			timer_a_irq[*3] |-> ##[2:4] irq_vec[8];
	endproperty
	a_sync_latency: assert property (p_sync_latency)    // [RULE18]
		else $error("synchronised interrupt late");

	property p_gate_during_transfer;
		@(posedge clk) disable iff (!rst_b)
		(state_r != APBSS_IDLE) |-> gated_periph_clk_en;
	endproperty
	a_gate_during_transfer: assert property (p_gate_during_transfer)    // [RULE7]
		else $error("clock gate released mid transfer");

	property p_ext_default_off;
		@(posedge clk) disable iff (!rst_b)
		(slot_psel[15:12] & ~ext_port_en) == 4'h0;
	endproperty
	a_ext_default_off: assert property (p_ext_default_off)    // [RULE6] [RULE12]
		else $error("disabled expansion port selected");

	// Checks the decode itself, not only the output mask
	property p_removed_units_quiet;
		@(posedge clk) disable iff (!rst_b)
		((sel_r | slot_psel) & ~slot_en) == 16'h0000;
	endproperty
	a_removed_units_quiet: assert property (p_removed_units_quiet)    // [RULE1] [RULE2] [RULE3] [RULE4]
		else $error("removed unit selected");

	property p_idle_slots_quiet;
		@(posedge clk) disable iff (!rst_b)
		(state_r == APBSS_IDLE) |-> (slot_psel == 16'h0000 && !slot_penable && !pready);
	endproperty
	a_idle_slots_quiet: assert property (p_idle_slots_quiet)    // [RULE20]
		else $error("slot driven while idle");

	property p_slot_hold_until_ready;
		@(posedge clk) disable iff (!rst_b)
		(slot_penable && !rsp_mux.pready) |=>
			(slot_penable && $stable(slot_psel) && $stable(slot_req));
	endproperty
	a_slot_hold_until_ready: assert property (p_slot_hold_until_ready)    // [RULE19]
		else $error("slot request dropped before ready");

endmodule

//--- bench/apbss_slot_model.sv
// ==========================================================
// Slot responders: wait states from paddr[3:2], error on paddr[4]
// ==========================================================
module apbss_slot_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Slot side of the subsystem
	input wire apbss_pkg::apbss_req_t slot_req,
	input wire logic slot_penable,
	input wire logic [15:0] slot_psel,
	output apbss_pkg::apbss_rsp_t [15:0] slot_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import apbss_pkg::*;
	logic [31:0] mem_r [16];
	logic [1:0] cnt_r;
	logic [31:0] noise_r;
	logic [3:0] sel;
	logic done;
	always_comb begin
		sel = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (slot_psel[i]) begin
				sel = 4'(i);
			end
		end
		done = slot_penable && (slot_psel != 16'h0000) && (cnt_r == slot_req.paddr[3:2]);
		// Idle slots show a changing pattern, never the last answer
		for (int i = 0; i < 16; i++) begin
			slot_rsp[i] = '{1'b0, noise_r, noise_r[0]};
		end
		if (done) begin
			slot_rsp[sel] = '{1'b1, mem_r[sel], slot_req.paddr[4]};
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 2'h0;
			noise_r <= 32'h5A5A_A5A5;
			for (int i = 0; i < 16; i++) begin
				mem_r[i] <= 32'h0000_0000;
			end
		end else begin
			noise_r <= ~noise_r;
			if (done) begin
				cnt_r <= 2'h0;
				if (slot_req.pwrite) begin
					mem_r[sel] <= slot_req.pwdata;
				end
			end else if (slot_penable) begin
				cnt_r <= cnt_r + 2'h1;
			end
		end
	end
endmodule

//--- bench/test_apbss_top.sv
module test_apbss_top;
	timeunit 1ns;
	timeprecision 1ps;
	import apbss_pkg::*;
	localparam logic [3:0] EXT = 4'b0101;
	logic clk, rst_b, psel, penable, pwrite, bus_activity_flag, gclk_en, pready, pslverr;
	logic [15:0] paddr, slot_psel;
	logic [31:0] pwdata, prdata, irq_vec, exp_mem [16];
	logic [2:0] rx, tx, ovf;
	logic ta, tb, tw, slot_penable;
	apbss_req_t slot_req;
	apbss_rsp_t [15:0] slot_rsp;
	int errors, tests_run;
	apbss_top #(.include_serial_b(1'b0), .big_endian_sel(1'b1), .ext_port_en(EXT)) uut (
		.clk(clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.bus_activity_flag(bus_activity_flag), .gated_periph_clk_en(gclk_en),
		.slot_req(slot_req), .slot_penable(slot_penable), .slot_psel(slot_psel),
		.slot_rsp(slot_rsp), .serial_rx_irq(rx), .serial_tx_irq(tx), .serial_ovf_irq(ovf),
		.timer_a_irq(ta), .timer_b_irq(tb), .twin_timer_irq(tw), .irq_vec(irq_vec));
	apbss_slot_model far (.clk(clk), .rst_b(rst_b), .slot_req(slot_req),
		.slot_penable(slot_penable), .slot_psel(slot_psel), .slot_rsp(slot_rsp));
	// ==========================================================
	// Checking helpers
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	function automatic logic en_slot(input int s);
		return (s inside {0, 1, 2, 4, 6, 8, 11}) || (s >= 12 && EXT[s-12]);
	endfunction
	function automatic logic [31:0] exp_irq();
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int u = 0; u < 3; u++) begin
			if (u != 1) begin
				v[2*u] = rx[u];
				v[2*u+1] = tx[u];
				v[12+u] = ovf[u];
			end
		end
		v[8] = ta;
		v[9] = tb;
		v[10] = tw;
		return v;
	endfunction
	// ==========================================================
	// APB transfer with expectations
	// ==========================================================
	task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
		int s, n;
		logic e;
		logic [15:0] seen;
		logic [31:0] pw;
		s = int'(a[15:12]);
		e = en_slot(s);
		seen = 16'h0000;
		pw = 32'h0000_0000;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			seen |= slot_psel;
			if (slot_psel != 16'h0000) begin
				pw = slot_req.pwdata;
			end
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk({31'h0, pready}, 32'h0000_0001, "ready");
		chk({16'h0, seen}, e ? 32'(1) << s : 32'h0000_0000, "slot select");
		chk(prdata, (e && !w) ? exp_mem[s] : 32'h0000_0000, "read data");
		chk({31'h0, pslverr}, {31'h0, e & a[4]}, "error");
		// Big-endian build swaps bytes on the way to the slot
		if (e) begin
			chk(pw, {d[7:0], d[15:8], d[23:16], d[31:24]}, "write lanes");
		end
		if (e && w) begin
			exp_mem[s] = d;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic complete_run();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#50000;
		errors++;
		complete_run();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rx, tx, ovf, ta, tb, tw} = '0;
		bus_activity_flag = 1'b0;
		errors = 0;
		tests_run = 0;
		for (int i = 0; i < 16; i++) begin
			exp_mem[i] = 32'h0000_0000;
		end
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		void'($urandom(31573));
		// Every slot written and read, slowest and error flavours
		for (int s = 0; s < 16; s++) begin
			xfer({4'(s), 12'h00C}, 1'b1, $urandom());
			xfer({4'(s), 12'h014}, 1'b0, 32'h0000_0000);
		end
		repeat (40) begin
			xfer(16'($urandom()), 1'($urandom()), $urandom());
		end
		// Idle clock gating follows the bridge activity flag
		@(posedge clk);
		bus_activity_flag <= 1'b1;
		@(negedge clk);
		chk({31'h0, gclk_en}, 32'h0000_0001, "gate on");
		@(posedge clk);
		bus_activity_flag <= 1'b0;
		@(negedge clk);
		chk({31'h0, gclk_en}, 32'h0000_0000, "gate off");
		// Interrupt lanes, corners first
		for (int k = 0; k < 30; k++) begin
			@(posedge clk);
			{rx, tx, ovf, ta, tb, tw} <= (k == 0) ? 12'hFFF : (k == 1) ? 12'h000 : 12'($urandom());
			@(negedge clk);
			chk(irq_vec, exp_irq(), "irq vector");
		end
		complete_run();
	end
endmodule
